// File: universal_serial_shift_unit.sv
// Purpose: Serial shift engine with edge counter and two-wire control
// Assumes: CPU bus on core_clk, pins asynchronous, timerOvf a pulse
// Notes: Read data appears one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "uss_defines.svh"

// Behaviour
// [R01] 8-bit shift register read and written directly, no buffer.
// [R02] Data out follows top bit through a latch, opposite sampling edge.
// [R03] Serial input always comes from the data input pin.
// [R04] 4-bit counter, CPU readable and writable, clocked with shifter.
// [R05] External clock: counter advances on both clock edges; with strobe select set it counts only toggle strobes.
// [R06] Two-wire mode holds clock low after start; hold mode also after wrap.
// [R07] Write coinciding with a shift wins; shift is dropped.
// [R08] Left shift from external edge, timer overflow or strobe.
// [R09] Wire mode off still lets shifter use data and clock inputs.
// [R10] External clock: latch open first half; internal: always open.
// [R11] Data drives out only when its direction bit is output.
// [R12] Status: start, wrap, stop, collision, count; resets to zero.
// [R13] Software writes status whole; a written one clears a flag.
// [R14] Two-wire mode sets start flag on start condition.
// [R15] Other modes, external clock, no strobe: clock edge sets start.
// [R16] Start request when start flag and both enables set.
// [R17] Start flag cleared by writing one; releases start hold.
// [R18] Start request wakes processor from every sleep mode.
// [R19] Wrap flag set when counter goes from 15 to 0.
// [R20] Wrap request when wrap flag and both enables set.
// [R21] Wrap flag cleared by writing one; releases wrap hold.
// [R22] Partners keep two-wire clock at most core clock over 16.
// [R23] Clock select and strobe select choose shift and count sources.
// [R24] Wire mode selects off, three-wire, two-wire, two-wire with hold.
// [R25] Two-wire stop condition sets stop flag; write one clears.
// [R26] Two-wire: collision reads one when top bit differs from pin.
module universal_serial_shift_unit (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [5:0] cpuAddr,
	input wire logic [7:0] cpuWrData,
	input wire logic cpuWrEn,
	input wire logic cpuRdEn,
	output logic [7:0] cpuRdData,
	input wire logic globalIrqEnable,
	input wire logic timerOvf,
	input wire logic portDataBit,
	input wire logic dirDo,
	input wire logic dirData,
	input wire logic dirClk,
	input wire logic dataPinIn,
	input wire logic clkPinIn,
	output logic dataPinOut,
	output logic dataPinOe_n,
	output logic clkPinOut,
	output logic clkPinOe_n,
	output logic doPinOut,
	output logic doPinOe_n,
	output logic startIrqReq,
	output logic wrapIrqReq,
	output logic wakeReq
);

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [1:0] pinLvl;
	logic [1:0] pinRise;
	logic [1:0] pinFall;

	uss_pin_sync #(.WIDTH(2)) u_sync (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.pinIn({clkPinIn, dataPinIn}),
		.level(pinLvl),
		.rise(pinRise),
		.fall(pinFall)
	);

	logic sdaLvl;
	logic sclLvl;
	assign sdaLvl = pinLvl[0];
	assign sclLvl = pinLvl[1];

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [7:0] shiftData;
	logic [3:0] edgeCount;
	logic startFlag;
	logic wrapFlag;
	logic stopFlag;
	logic startIrqEn;
	logic wrapIrqEn;
	logic [1:0] wireMode;
	logic [1:0] clkSel;
	logic strobeSel;
	logic clockDriveBit;
	logic latchBit;

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	logic wrCtrl;
	logic wrStatus;
	logic wrData;
	assign wrCtrl = cpuWrEn && (cpuAddr == `USS_ADDR_CTRL);
	assign wrStatus = cpuWrEn && (cpuAddr == `USS_ADDR_STATUS);
	assign wrData = cpuWrEn && (cpuAddr == `USS_ADDR_DATA);

	uss_pkg::uss_wire_e wm;
	uss_pkg::uss_clksel_e cs;
	assign wm = uss_pkg::uss_wire_e'(wireMode);
	assign cs = uss_pkg::uss_clksel_e'(clkSel);

	logic twoWire;
	logic extClk;
	assign twoWire = wireMode[1];
	assign extClk = clkSel[1];

	// ------------------------------------------------------------------
	// Clock sources
	// ------------------------------------------------------------------
	logic swStrobe;
	logic tcStrobe;
	logic extShift;
	logic anyEdge;
	logic shiftEvt;
	logic cntEvt;

	assign swStrobe = wrCtrl && cpuWrData[`USS_CT_STROBE]
		&& (cpuWrData[`USS_CT_CS_HI:`USS_CT_CS_LO] == 2'b00); // [R23]
	assign tcStrobe = wrCtrl && cpuWrData[`USS_CT_TOGGLE]
		&& cpuWrData[`USS_CT_STROBE] && cpuWrData[`USS_CT_CS_HI];
	assign anyEdge = pinRise[1] | pinFall[1];

	always_comb begin
		extShift = 1'b0;
		unique case (cs)
			uss_pkg::USS_CS_SOFT: extShift = 1'b0;
			uss_pkg::USS_CS_TIMER: extShift = 1'b0;
			uss_pkg::USS_CS_EXT_POS: extShift = pinRise[1]; // [R23] [R09]
			uss_pkg::USS_CS_EXT_NEG: extShift = pinFall[1]; // [R23] [R09]
		endcase
	end

	assign shiftEvt = swStrobe | (cs == uss_pkg::USS_CS_TIMER && timerOvf)
		| extShift; // [R08]
	assign cntEvt = swStrobe | (cs == uss_pkg::USS_CS_TIMER && timerOvf)
		| (extClk && !strobeSel && anyEdge) // [R05]
		| tcStrobe; // [R04]

	// ------------------------------------------------------------------
	// Bus conditions
	// ------------------------------------------------------------------
	logic startCond;
	logic stopCond;
	logic startSet;
	logic stopSet;
	logic wrapSet;
	assign startCond = sclLvl && pinFall[0];
	assign stopCond = sclLvl && pinRise[0];
	assign startSet = (twoWire && startCond) // [R14]
		|| (!twoWire && extClk && !strobeSel && anyEdge); // [R15]
	assign stopSet = twoWire && stopCond; // [R25]
	assign wrapSet = cntEvt && (edgeCount == `USS_CNT_TOP) && !wrStatus;

	// ------------------------------------------------------------------
	// Shift register
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			shiftData <= `USS_RST_DATA;
		end else if (wrData) begin
			shiftData <= cpuWrData; // [R01] [R07]
		end else if (shiftEvt) begin
			shiftData <= {shiftData[6:0], sdaLvl}; // [R08] [R03]
		end
	end

	// ------------------------------------------------------------------
	// Edge counter
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			edgeCount <= `USS_RST_CNT;
		end else if (wrStatus) begin
			edgeCount <= cpuWrData[`USS_ST_CNT_HI:`USS_ST_CNT_LO]; // [R04]
		end else if (cntEvt) begin
			edgeCount <= edgeCount + 4'h1; // [R04] [R05]
		end
	end

	// ------------------------------------------------------------------
	// Flags, set wins over clear for start and stop; any status write blocks the wrap set
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			startFlag <= 1'b0;
			wrapFlag <= 1'b0;
			stopFlag <= 1'b0;
		end else begin
			if (startSet) begin
				startFlag <= 1'b1; // [R14] [R15]
			end else if (wrStatus && cpuWrData[`USS_ST_START]) begin
				startFlag <= 1'b0; // [R17]
			end
			if (wrapSet) begin
				wrapFlag <= 1'b1; // [R19]
			end else if (wrStatus && cpuWrData[`USS_ST_WRAP]) begin
				wrapFlag <= 1'b0; // [R21]
			end
			if (stopSet) begin
				stopFlag <= 1'b1; // [R25]
			end else if (wrStatus && cpuWrData[`USS_ST_STOP]) begin
				stopFlag <= 1'b0; // [R25]
			end
		end
	end

	// ------------------------------------------------------------------
	// Control register and clock port bit
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			{startIrqEn, wrapIrqEn} <= 2'b00;
			wireMode <= 2'b00;
			clkSel <= 2'b00;
			strobeSel <= 1'b0;
		end else if (wrCtrl) begin
			startIrqEn <= cpuWrData[`USS_CT_SIE];
			wrapIrqEn <= cpuWrData[`USS_CT_WIE];
			wireMode <= cpuWrData[`USS_CT_WM_HI:`USS_CT_WM_LO]; // [R24]
			clkSel <= cpuWrData[`USS_CT_CS_HI:`USS_CT_CS_LO]; // [R23]
			strobeSel <= cpuWrData[`USS_CT_STROBE];
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			clockDriveBit <= 1'b0;
		end else if (wrCtrl && cpuWrData[`USS_CT_TOGGLE]) begin
			clockDriveBit <= ~clockDriveBit;
		end
	end

	// ------------------------------------------------------------------
	// Output latch
	// ------------------------------------------------------------------
	logic latchOpen;
	assign latchOpen = !extClk || (clkSel[0] ? sclLvl : !sclLvl); // [R10]

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			latchBit <= 1'b0;
		end else if (latchOpen) begin
			latchBit <= shiftData[7]; // [R02] [R10]
		end
	end

	// ------------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------------
	logic clkHold;
	assign clkHold = (twoWire && startFlag) // [R06] [R17]
		|| (wm == uss_pkg::USS_WM_TWO_HOLD && wrapFlag); // [R06] [R21]

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			doPinOut <= 1'b0;
			doPinOe_n <= 1'b1;
			dataPinOut <= 1'b0;
			dataPinOe_n <= 1'b1;
			clkPinOut <= 1'b0;
			clkPinOe_n <= 1'b1;
		end else begin
			doPinOut <= latchBit; // [R02]
			doPinOe_n <= !(wm == uss_pkg::USS_WM_THREE && dirDo); // [R11]
			dataPinOut <= 1'b0;
			dataPinOe_n <= !(twoWire && dirData
				&& (!latchBit || !portDataBit)); // [R24] [R11]
			clkPinOut <= (wm == uss_pkg::USS_WM_THREE) ? clockDriveBit : 1'b0;
			if (wm == uss_pkg::USS_WM_THREE) begin
				clkPinOe_n <= !dirClk;
			end else begin
				clkPinOe_n <= !(twoWire && dirClk
					&& (!clockDriveBit || clkHold)); // [R06]
			end
		end
	end

	// ------------------------------------------------------------------
	// Requests
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			startIrqReq <= 1'b0;
			wrapIrqReq <= 1'b0;
			wakeReq <= 1'b0;
		end else begin
			startIrqReq <= startFlag && startIrqEn && globalIrqEnable; // [R16]
			wrapIrqReq <= wrapFlag && wrapIrqEn && globalIrqEnable; // [R20]
			wakeReq <= startFlag && startIrqEn; // [R18]
		end
	end

	// ------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------
	logic collision;
	assign collision = twoWire && (shiftData[7] != sdaLvl); // [R26]

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cpuRdData <= 8'h00;
		end else if (cpuRdEn) begin
			unique case (cpuAddr)
				`USS_ADDR_STATUS: cpuRdData <= {startFlag, wrapFlag, stopFlag,
					collision, edgeCount}; // [R12]
				`USS_ADDR_DATA: cpuRdData <= shiftData; // [R01]
				`USS_ADDR_CTRL: cpuRdData <= {startIrqEn, wrapIrqEn, wireMode,
					clkSel, 2'b00};
				default: cpuRdData <= 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	write_wins_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R07]
		wrData |=> shiftData == $past(cpuWrData))
		else $error("Data write lost");

	left_shift_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R08]
		shiftEvt && !wrData |=> shiftData == {$past(shiftData[6:0]),
			$past(sdaLvl)})
		else $error("Shift wrong");

	wrap_set_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R19]
		cntEvt && !wrStatus && edgeCount == 4'hf |=> wrapFlag && edgeCount == 4'h0)
		else $error("Wrap not flagged");

	start_irq_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R16]
		(startFlag && startIrqEn && globalIrqEnable) [*2] |-> startIrqReq)
		else $error("Start request missing");

	wrap_irq_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R20]
		$past(wrapFlag && wrapIrqEn) && !$past(globalIrqEnable) |-> !wrapIrqReq)
		else $error("Wrap request ungated");

	start_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R17]
		wrStatus && cpuWrData[7] && !startSet |=> !startFlag)
		else $error("Start flag not cleared");

	start_sticky_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R14]
		startSet |=> startFlag)
		else $error("Start event lost");

	scl_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R06]
		(twoWire && startFlag && dirClk) [*2] |-> !clkPinOe_n && !clkPinOut)
		else $error("Clock not held");

	do_dir_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R11]
		!dirDo |=> doPinOe_n)
		else $error("Data out driven without direction");

	count_both_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R05]
		extClk && !strobeSel && !wrStatus && pinFall[1]
		|=> edgeCount == $past(edgeCount) + 4'h1)
		else $error("Falling edge not counted");

endmodule : universal_serial_shift_unit

`default_nettype wire

// File: uss_defines.svh
// Purpose: Offsets, field positions, reset values of the serial shift unit
// Assumes: 6-bit CPU I/O address, 8-bit data
// Notes: Definitions only
`ifndef USS_DEFINES_SVH
`define USS_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define USS_ADDR_CTRL 6'h0d
`define USS_ADDR_STATUS 6'h0e
`define USS_ADDR_DATA 6'h0f

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define USS_ST_START 7
`define USS_ST_WRAP 6
`define USS_ST_STOP 5
`define USS_ST_COLL 4
`define USS_ST_CNT_HI 3
`define USS_ST_CNT_LO 0

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define USS_CT_SIE 7
`define USS_CT_WIE 6
`define USS_CT_WM_HI 5
`define USS_CT_WM_LO 4
`define USS_CT_CS_HI 3
`define USS_CT_CS_LO 2
`define USS_CT_STROBE 1
`define USS_CT_TOGGLE 0

// ----------------------------------------------------------------------
// Reset values and counter top
// ----------------------------------------------------------------------
`define USS_RST_STATUS 8'h00
`define USS_RST_CTRL 8'h00
`define USS_RST_DATA 8'h00
`define USS_RST_CNT 4'h0
`define USS_CNT_TOP 4'hf

`endif

// File: uss_pkg.sv
// Purpose: Types of the serial shift unit
// Assumes: Nothing
// Notes: Constants live in uss_defines.svh
package uss_pkg;

	typedef enum logic [1:0] {
		USS_WM_OFF = 2'b00,
		USS_WM_THREE = 2'b01,
		USS_WM_TWO = 2'b10,
		USS_WM_TWO_HOLD = 2'b11
	} uss_wire_e;

	typedef enum logic [1:0] {
		USS_CS_SOFT = 2'b00,
		USS_CS_TIMER = 2'b01,
		USS_CS_EXT_POS = 2'b10,
		USS_CS_EXT_NEG = 2'b11
	} uss_clksel_e;

endpackage : uss_pkg

// File: uss_pin_sync.sv
// Purpose: Two-stage synchroniser with edge detection for pin inputs
// Assumes: Inputs asynchronous to core_clk
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module uss_pin_sync #(
	parameter int WIDTH = 2
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] prev;

	// ------------------------------------------------------------------
	// Synchroniser and edge history
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			stage1 <= '1;
			stage2 <= '1;
			prev <= '1;
		end else begin
			stage1 <= pinIn;
			stage2 <= stage1;
			prev <= stage2;
		end
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_edge
			assign level[i] = stage2[i];
			assign rise[i] = stage2[i] & ~prev[i];
			assign fall[i] = ~stage2[i] & prev[i];
		end
	endgenerate

endmodule : uss_pin_sync

`default_nettype wire

// File: uss_bus_model.sv
// Purpose: Far-side serial bus device for the serial shift unit
// Assumes: Pull-ups on both lines, steps counted in core_clk cycles
// Notes: Lines resolve as wired-and of both parties
`timescale 1ns/1ps
`default_nettype none

module uss_bus_model #(
	parameter int STEP = 4
) (
	input wire logic core_clk,
	input wire logic dataPinOut,
	input wire logic dataPinOe_n,
	input wire logic clkPinOut,
	input wire logic clkPinOe_n,
	output logic dataPinIn,
	output logic clkPinIn
);
	logic sdaLow = 1'b0;
	logic sclLow = 1'b0;

	// ------------------------------------------------------------
	// Line resolution
	// ------------------------------------------------------------
	assign dataPinIn = (dataPinOe_n | dataPinOut) & !sdaLow;
	assign clkPinIn = (clkPinOe_n | clkPinOut) & !sclLow;

	task automatic pause(input int n);
		repeat (n) @(posedge core_clk);
	endtask : pause

	// Set both lines, one means released
	task automatic lines(input logic sda, input logic scl);
		sdaLow <= !sda;
		sclLow <= !scl;
		pause(2 * STEP);
	endtask : lines

	// Three-wire master, data set while clock low
	task automatic send_bits(input logic [3:0] bits);
		for (int i = 3; i >= 0; i--) begin
			sdaLow <= !bits[i];
			pause(STEP);
			sclLow <= 1'b0;
			pause(STEP);
			sclLow <= 1'b1;
		end
		pause(2 * STEP);
	endtask : send_bits

	// Start and stop with clock high, slow steps
	task automatic start_cond();
		sdaLow <= 1'b1;
		pause(2 * STEP);
	endtask : start_cond

	task automatic stop_cond();
		sdaLow <= 1'b0;
		pause(2 * STEP);
	endtask : stop_cond
endmodule : uss_bus_model

`default_nettype wire

// File: testbench.sv
// Purpose: Self-checking bench for the serial shift unit
// Assumes: Register map of uss_defines.svh
// Notes: Partner model drives the serial pins
`timescale 1ns/1ps
`default_nettype none
`include "uss_defines.svh"

module testbench;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [5:0] cpuAddr = 6'h00;
	logic [7:0] cpuWrData = 8'h00;
	logic cpuWrEn = 1'b0;
	logic cpuRdEn = 1'b0;
	logic [7:0] cpuRdData;
	logic globalIrqEnable = 1'b0;
	logic timerOvf = 1'b0;
	logic portDataBit = 1'b1;
	logic dirDo = 1'b0;
	logic dirData = 1'b0;
	logic dirClk = 1'b0;
	logic dataPinIn, clkPinIn, dataPinOut, dataPinOe_n, clkPinOut;
	logic clkPinOe_n, doPinOut, doPinOe_n, startIrqReq, wrapIrqReq, wakeReq;
	int failures = 0;
	int num_checks = 0;

	always #20 core_clk = !core_clk;

	universal_serial_shift_unit uut (.core_clk(core_clk), .sys_rst(sys_rst),
		.cpuAddr(cpuAddr), .cpuWrData(cpuWrData), .cpuWrEn(cpuWrEn),
		.cpuRdEn(cpuRdEn), .cpuRdData(cpuRdData),
		.globalIrqEnable(globalIrqEnable), .timerOvf(timerOvf),
		.portDataBit(portDataBit), .dirDo(dirDo), .dirData(dirData),
		.dirClk(dirClk), .dataPinIn(dataPinIn), .clkPinIn(clkPinIn),
		.dataPinOut(dataPinOut), .dataPinOe_n(dataPinOe_n),
		.clkPinOut(clkPinOut), .clkPinOe_n(clkPinOe_n), .doPinOut(doPinOut),
		.doPinOe_n(doPinOe_n), .startIrqReq(startIrqReq),
		.wrapIrqReq(wrapIrqReq), .wakeReq(wakeReq));

	uss_bus_model uPart (.core_clk(core_clk), .dataPinOut(dataPinOut),
		.dataPinOe_n(dataPinOe_n), .clkPinOut(clkPinOut),
		.clkPinOe_n(clkPinOe_n), .dataPinIn(dataPinIn), .clkPinIn(clkPinIn));

	// ------------------------------------------------------------
	// Bus and compare tasks
	// ------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc

	task automatic wr(input logic [5:0] a, input logic [7:0] d,
		input logic ovf = 1'b0);
		cpuAddr <= a;
		cpuWrData <= d;
		cpuWrEn <= 1'b1;
		timerOvf <= ovf;
		cyc(1);
		cpuWrEn <= 1'b0;
		timerOvf <= 1'b0;
		cyc(1);
	endtask : wr

	task automatic chk8(input string n, input logic [7:0] e,
		input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk8

	task automatic chk1(input string n, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %b seen %b", n, e, g);
		end
	endtask : chk1

	task automatic rdchk(input logic [5:0] a, input logic [7:0] e,
		input string n);
		cpuAddr <= a;
		cpuRdEn <= 1'b1;
		cyc(1);
		cpuRdEn <= 1'b0;
		cyc(1);
		chk8(n, e, cpuRdData);
	endtask : rdchk

	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test

	initial begin
		cyc(20000);
		failures++;
		stop_test();
	end

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		logic [7:0] c;
		cyc(16);
		sys_rst <= 1'b0;
		cyc(3);
		rdchk(`USS_ADDR_STATUS, `USS_RST_STATUS, "status");
		rdchk(`USS_ADDR_DATA, `USS_RST_DATA, "data");
		rdchk(6'h10, 8'h00, "unmapped");
		chk1("do oe_n", 1'b1, doPinOe_n);
		$display("test reset done");

		wr(`USS_ADDR_DATA, 8'ha5);
		rdchk(`USS_ADDR_DATA, 8'ha5, "data rw");
		wr(`USS_ADDR_CTRL, 8'h02);
		rdchk(`USS_ADDR_DATA, 8'h4b, "strobe shift");
		rdchk(`USS_ADDR_STATUS, 8'h01, "strobe count");
		$display("test strobe done");

		for (int m = 0; m < 2; m++) begin
			c = (m == 0) ? 8'h18 : 8'h08;
			uPart.lines(1'b1, 1'b0);
			wr(`USS_ADDR_CTRL, c);
			wr(`USS_ADDR_STATUS, 8'he0);
			wr(`USS_ADDR_DATA, 8'h80);
			dirDo <= 1'b1;
			cyc(3);
			if (m == 0) chk1("do latch", 1'b1, doPinOut);
			chk1("do oe_n", (m == 0) ? 1'b0 : 1'b1, doPinOe_n);
			if (m == 0) chk1("sck out", 1'b0, clkPinOut);
			uPart.send_bits(4'b1011);
			rdchk(`USS_ADDR_DATA, 8'h0b, "ext shift");
			rdchk(`USS_ADDR_STATUS, 8'h88, "edges");
			if (m == 0) chk1("do after", 1'b0, doPinOut);
			dirDo <= 1'b0;
		end
		$display("test external done");

		wr(`USS_ADDR_CTRL, 8'h1b);
		cyc(1);
		chk1("sck toggle", 1'b1, clkPinOut);
		wr(`USS_ADDR_CTRL, 8'h1b);
		rdchk(`USS_ADDR_STATUS, 8'h8a, "toggle count");
		$display("test toggle done");

		wr(`USS_ADDR_STATUS, 8'hcf);
		globalIrqEnable <= 1'b1;
		wr(`USS_ADDR_CTRL, 8'h42);
		rdchk(`USS_ADDR_STATUS, 8'h40, "wrap");
		chk1("wrap req", 1'b1, wrapIrqReq);
		globalIrqEnable <= 1'b0;
		cyc(2);
		chk1("wrap req", 1'b0, wrapIrqReq);
		wr(`USS_ADDR_STATUS, 8'h40);
		rdchk(`USS_ADDR_STATUS, 8'h00, "wrap clear");
		$display("test wrap done");

		wr(`USS_ADDR_CTRL, 8'h04);
		wr(`USS_ADDR_DATA, 8'h81);
		wr(6'h10, 8'h00, 1'b1);
		rdchk(`USS_ADDR_DATA, 8'h03, "timer shift");
		rdchk(`USS_ADDR_STATUS, 8'h01, "timer count");
		wr(`USS_ADDR_DATA, 8'h3c, 1'b1);
		rdchk(`USS_ADDR_DATA, 8'h3c, "write wins");
		$display("test timer done");

		uPart.lines(1'b1, 1'b1);
		wr(`USS_ADDR_CTRL, 8'h20);
		wr(`USS_ADDR_STATUS, 8'he0);
		wr(`USS_ADDR_DATA, 8'h80);
		dirClk <= 1'b1;
		globalIrqEnable <= 1'b1;
		wr(`USS_ADDR_CTRL, 8'ha1);
		rdchk(`USS_ADDR_CTRL, 8'ha0, "ctrl");
		cyc(3);
		chk1("scl free", 1'b1, clkPinOe_n);
		uPart.start_cond();
		rdchk(`USS_ADDR_STATUS, 8'h90, "start");
		chk1("start req", 1'b1, startIrqReq);
		chk1("wake", 1'b1, wakeReq);
		chk1("scl hold", 1'b0, clkPinOe_n);
		wr(`USS_ADDR_STATUS, 8'h80);
		cyc(2);
		chk1("scl free", 1'b1, clkPinOe_n);
		chk1("start req", 1'b0, startIrqReq);
		uPart.stop_cond();
		rdchk(`USS_ADDR_STATUS, 8'h20, "stop");
		wr(`USS_ADDR_DATA, 8'h00);
		dirData <= 1'b1;
		cyc(3);
		chk1("sda low", 1'b0, dataPinOe_n);
		chk1("sda out", 1'b0, dataPinOut);
		dirData <= 1'b0;
		cyc(3);
		chk1("sda off", 1'b1, dataPinOe_n);
		$display("test two-wire done");
		stop_test();
	end
endmodule : testbench

`default_nettype wire
